// file: rtl/sbr_pkg.sv
// Constants and types for the standby and reset controller
package sbr_pkg;

    // ======================================================
    // Request sources, lowest index has highest priority
    localparam int SRC_N = 5;
    localparam int SRC_EXT = 0;
    localparam int SRC_TMA = 1;
    localparam int SRC_TMB = 2;
    localparam int SRC_ITV = 3;
    localparam int SRC_SER = 4;

    // ======================================================
    // Standby operand bit positions
    localparam int OP_IRQ = 3;
    localparam int OP_RSV = 2;
    localparam int OP_TMB = 1;
    localparam int OP_PIN = 0;
    localparam logic [3:0] OP_ZERO = 4'h0;
    localparam logic [3:0] STOP_OP_MASK = 4'h9;

    // ======================================================
    // Addresses and reset values
    localparam logic [10:0] ADDR_RESET = 11'h000;
    localparam logic [10:0] VEC_TOP = 11'h005;
    localparam logic [2:0] SP_RESET = 3'h5;
    localparam logic [7:0] TMR_MOD_RESET = 8'hff;

    // ======================================================
    // Reset kinds and controller states
    typedef enum logic [1:0] {
        RK_EXT = 2'h0,
        RK_WDT = 2'h1,
        RK_STK = 2'h2,
        RK_STOP0 = 2'h3
    } sbr_kind_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_HALT = 5'h02,
        ST_STOP = 5'h04,
        ST_HOLD = 5'h08,
        ST_SETTLE = 5'h10
    } sbr_state_t;

endpackage

// file: rtl/sbr_standby_reset_ctrl.sv
// Standby mode sequencing, wake-up, settling wait and reset control
`timescale 1ns/100ps
module sbr_standby_reset_ctrl
    import sbr_pkg::*;
#(
    parameter int RESET_SETTLE_PULSES = 256,
    parameter int RESET_SETTLE_DIV = 128
)(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic resetPinN,
    input wire logic powerOnDetector,
    input wire logic wakePinN,
    input wire logic watchdogOverflow,
    input wire logic stackFault,
    input wire logic haltInstr,
    input wire logic stopInstr,
    input wire logic [3:0] standbyOperand,
    input wire logic [SRC_N-1:0] sourceRequestFlag,
    input wire logic [SRC_N-1:0] sourceEnableBit,
    input wire logic irqEnableInstr,
    input wire logic irqDisableInstr,
    input wire logic irqAccept,
    input wire logic [7:0] timerBModulo,
    input wire logic [7:0] timerBDivisor,
    input wire logic timerAPinSource,
    input wire logic serialExtClock,
    output logic oscRun,
    output logic cpuClockEn,
    output logic coreReset,
    output logic initPulse,
    output logic [1:0] resetKind,
    output logic keepDataMemory,
    output logic portLatchClear,
    output logic timerBCountClear,
    output logic portsForceInput,
    output logic pcLoad,
    output logic [10:0] pcLoadAddr,
    output logic resumeNext,
    output logic globalIrqEnable,
    output logic timerARun,
    output logic timerBRun,
    output logic timerBClear,
    output logic intervalTimerRun,
    output logic serialRun,
    output logic adcRun,
    output logic conversionResultClear,
    output logic [2:0] stackPointerInit,
    output logic [7:0] timerModuloInit
);

    // ======================================================
    // Pin synchronisers
    logic resetPinMeta_reg, resetPinSync_reg;
    logic porMeta_reg, porSync_reg;
    logic wakeMeta_reg, wakeSync_reg;

    // Two flops each, first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            resetPinMeta_reg <= 1'b1;
            resetPinSync_reg <= 1'b1;
            porMeta_reg <= 1'b0;
            porSync_reg <= 1'b0;
            wakeMeta_reg <= 1'b1;
            wakeSync_reg <= 1'b1;
        end else begin
            resetPinMeta_reg <= resetPinN;
            resetPinSync_reg <= resetPinMeta_reg;
            porMeta_reg <= powerOnDetector;
            porSync_reg <= porMeta_reg;
            wakeMeta_reg <= wakePinN;
            wakeSync_reg <= wakeMeta_reg;
        end
    end

    // ======================================================
    // Wake and block conditions
    sbr_state_t state_reg, state_next;
    logic [3:0] op_reg;
    logic settleReset_reg;
    logic [7:0] settleN_reg, settleM_reg;
    logic [7:0] divCnt_reg, pulseCnt_reg;
    logic resumeVec_reg;
    logic [10:0] resumeAddr_reg;
    logic [SRC_N-1:0] pendEn;
    logic anyPend, pinLow, extReset, softReset;
    logic haltEnter, stopEnter, haltWake, stopWake, settleDone, stop0Entry;
    logic [7:0] divLast;
    logic [10:0] vecAddrNow;
    logic vecHitHalt, vecHitStop;

    assign pendEn = sourceRequestFlag & sourceEnableBit;
    assign anyPend = |pendEn;
    assign pinLow = ~wakeSync_reg;
    assign extReset = ~resetPinSync_reg | porSync_reg;
    assign softReset = (watchdogOverflow | stackFault) & (state_reg == ST_HALT || state_reg == ST_RUN);

    // Fixed priority vector, external source first
    always_comb begin
        vecAddrNow = VEC_TOP;
        for (int i = SRC_N - 1; i >= 0; i--) begin
            if (pendEn[i]) begin
                vecAddrNow = VEC_TOP - 11'(i);
            end
        end
    end

    // Forced timer B wake looks at the raw flag, others need the enable
    assign haltWake = (op_reg[OP_IRQ] & anyPend)
        | (op_reg[OP_TMB] & sourceRequestFlag[SRC_TMB])
        | (op_reg[OP_PIN] & pinLow);
    // Bits 2 and 1 are ignored here, so the forced timer B wake never applies to deep sleep
    assign stopWake = (op_reg[OP_IRQ] & anyPend) | (op_reg[OP_PIN] & pinLow);

    // Suspend entry refused while its own wake condition already holds; deep sleep entry also refused whenever the wake pin is low
    assign haltEnter = haltInstr & ~((standbyOperand[OP_IRQ] & anyPend)
        | (standbyOperand[OP_TMB] & sourceRequestFlag[SRC_TMB])
        | (standbyOperand[OP_PIN] & pinLow));
    assign stopEnter = stopInstr & ~(standbyOperand[OP_IRQ] & anyPend) & ~pinLow;

    assign vecHitHalt = globalIrqEnable & op_reg[OP_IRQ] & anyPend;
    assign vecHitStop = globalIrqEnable & op_reg[OP_IRQ] & anyPend;

    assign divLast = (settleM_reg == 8'h00) ? 8'h00 : settleM_reg - 8'h01;
    assign settleDone = (state_reg == ST_SETTLE) && (divCnt_reg == divLast) && (pulseCnt_reg == settleN_reg);

    // ======================================================
    // State transitions
    always_comb begin
        state_next = state_reg;
        if (extReset) begin
            state_next = ST_HOLD;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (softReset) begin
                        state_next = ST_RUN;
                    end else if (haltEnter) begin
                        state_next = ST_HALT;
                    end else if (stopEnter) begin
                        state_next = ST_STOP;
                    end
                end
                ST_HALT: begin
                    if (softReset || (op_reg != OP_ZERO && haltWake)) begin
                        state_next = ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (op_reg != OP_ZERO && stopWake) begin
                        state_next = ST_SETTLE;
                    end
                end
                ST_HOLD: begin
                    state_next = ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (settleDone) begin
                        state_next = ST_RUN;
                    end
                end
            endcase
        end
    end

    // State and latched operand
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_HOLD;
            op_reg <= OP_ZERO;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_RUN && state_next == ST_HALT) begin
                op_reg <= standbyOperand & ~(4'h1 << OP_RSV);
            end else if (state_reg == ST_RUN && state_next == ST_STOP) begin
                op_reg <= standbyOperand & STOP_OP_MASK;
            end
        end
    end

    // ======================================================
    // Settling wait, built as timer B with prescaler
    // Divisor and modulo are frozen at sleep entry so later writes cannot stretch the wait
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            settleN_reg <= 8'(RESET_SETTLE_PULSES - 1);
            settleM_reg <= 8'(RESET_SETTLE_DIV);
            settleReset_reg <= 1'b1;
        end else if (state_next == ST_HOLD) begin
            settleN_reg <= 8'(RESET_SETTLE_PULSES - 1);
            settleM_reg <= 8'(RESET_SETTLE_DIV);
            settleReset_reg <= 1'b1;
        end else if (state_reg == ST_RUN && state_next == ST_STOP) begin
            settleN_reg <= timerBModulo;
            settleM_reg <= timerBDivisor;
            settleReset_reg <= 1'b0;
        end
    end

    // Prescaler and pulse counter, idle outside the wait
    always_ff @(posedge ref_clk) begin
        if (srst || state_reg != ST_SETTLE) begin
            divCnt_reg <= 8'h00;
            pulseCnt_reg <= 8'h00;
        end else if (divCnt_reg == divLast) begin
            divCnt_reg <= 8'h00;
            pulseCnt_reg <= pulseCnt_reg + 8'h01;
        end else begin
            divCnt_reg <= divCnt_reg + 8'h01;
        end
    end

    // Resume target chosen at the wake moment, used when the wait ends
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            resumeVec_reg <= 1'b0;
            resumeAddr_reg <= ADDR_RESET;
        end else if (state_reg == ST_STOP && state_next == ST_SETTLE) begin
            resumeVec_reg <= vecHitStop;
            resumeAddr_reg <= vecAddrNow;
        end
    end

    // ======================================================
    // Global interrupt enable
    // Disable and acceptance win over a same-cycle enable
    // Zero operand deep sleep counts as a reset, so it drops the enable too
    always_ff @(posedge ref_clk) begin
        if (srst || extReset || softReset || stop0Entry) begin
            globalIrqEnable <= 1'b0;
        end else if (irqDisableInstr || irqAccept || (pcLoad && pcLoadAddr != ADDR_RESET)) begin
            globalIrqEnable <= 1'b0;
        end else if (irqEnableInstr) begin
            globalIrqEnable <= 1'b1;
        end
    end

    // ======================================================
    // Reset and resume events
    logic resetDone, haltResume, stopResume;

    assign resetDone = settleDone & settleReset_reg;
    assign stop0Entry = state_reg == ST_RUN && state_next == ST_STOP && standbyOperand == OP_ZERO;
    assign haltResume = state_reg == ST_HALT && state_next == ST_RUN && !softReset;
    assign stopResume = settleDone & ~settleReset_reg & ~extReset;

    // One-cycle strobes toward the core
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            initPulse <= 1'b0;
            pcLoad <= 1'b0;
            pcLoadAddr <= ADDR_RESET;
            resumeNext <= 1'b0;
            resetKind <= RK_EXT;
            portLatchClear <= 1'b0;
            timerBCountClear <= 1'b0;
        end else begin
            initPulse <= (resetDone | softReset | stop0Entry) & ~extReset;
            pcLoad <= 1'b0;
            pcLoadAddr <= ADDR_RESET;
            resumeNext <= 1'b0;
            portLatchClear <= 1'b0;
            timerBCountClear <= 1'b0;
            if (extReset) begin
                resetKind <= RK_EXT;
            end else if (softReset) begin
                resetKind <= watchdogOverflow ? RK_WDT : RK_STK;
                pcLoad <= 1'b1;
            end else if (resetDone || stop0Entry) begin
                resetKind <= stop0Entry ? RK_STOP0 : RK_EXT;
                pcLoad <= resetDone;
                portLatchClear <= 1'b1;
                timerBCountClear <= 1'b1;
            end else if (haltResume) begin
                pcLoad <= vecHitHalt;
                pcLoadAddr <= vecHitHalt ? vecAddrNow : ADDR_RESET;
                resumeNext <= ~vecHitHalt;
            end else if (stopResume) begin
                pcLoad <= resumeVec_reg;
                pcLoadAddr <= resumeVec_reg ? resumeAddr_reg : ADDR_RESET;
                resumeNext <= ~resumeVec_reg;
            end
        end
    end

    // Memory kept only when a pin or detector reset arrives during standby
    always_ff @(posedge ref_clk) begin
        if (srst || softReset) begin
            keepDataMemory <= 1'b0;
        end else if (state_next == ST_HOLD && state_reg != ST_HOLD) begin
            keepDataMemory <= state_reg == ST_HALT || state_reg == ST_STOP;
        end
    end

    // Preset values driven during and after every reset
    always_ff @(posedge ref_clk) begin
        stackPointerInit <= SP_RESET;
        timerModuloInit <= TMR_MOD_RESET;
    end

    // ======================================================
    // Clock gating and peripheral run enables, from the next state
    logic stopNext, stop0Next;

    assign stopNext = state_next == ST_STOP;
    assign stop0Next = stopNext && (state_reg == ST_STOP ? op_reg == OP_ZERO : standbyOperand == OP_ZERO);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            oscRun <= 1'b0;
            cpuClockEn <= 1'b0;
            coreReset <= 1'b1;
            portsForceInput <= 1'b1;
            timerARun <= 1'b0;
            timerBRun <= 1'b0;
            timerBClear <= 1'b1;
            intervalTimerRun <= 1'b0;
            serialRun <= 1'b0;
            adcRun <= 1'b0;
            conversionResultClear <= 1'b1;
        end else begin
            oscRun <= ~(stopNext | state_next == ST_HOLD);
            cpuClockEn <= state_next == ST_RUN;
            coreReset <= state_next == ST_HOLD || (state_next == ST_SETTLE && settleReset_reg);
            portsForceInput <= stop0Next || state_next == ST_HOLD || softReset;
            timerARun <= stopNext ? timerAPinSource : state_next != ST_HOLD;
            timerBRun <= ~stopNext & (state_next != ST_HOLD);
            timerBClear <= stopNext | state_next == ST_HOLD;
            intervalTimerRun <= ~stopNext & (state_next != ST_HOLD);
            serialRun <= stopNext ? serialExtClock : state_next != ST_HOLD;
            adcRun <= ~stopNext & (state_next != ST_HOLD);
            conversionResultClear <= stopNext | state_next == ST_HOLD;
        end
    end

    // ======================================================
    // Checks
    logic [16:0] settleCycles_reg;
    logic [16:0] settleTarget;

    assign settleTarget = (17'(settleN_reg) + 17'h00001) * 17'(settleM_reg == 8'h00 ? 8'h01 : settleM_reg);

    // Cycle count of the current wait
    always_ff @(posedge ref_clk) begin
        if (srst || state_reg != ST_SETTLE) begin
            settleCycles_reg <= 17'h00001;
        end else begin
            settleCycles_reg <= settleCycles_reg + 17'h00001;
        end
    end

    sequence seqHaltWake;
        state_reg == ST_HALT && op_reg != OP_ZERO && haltWake && vecHitHalt && !extReset && !softReset;
    endsequence

    sequence seqStop0Entry;
        stop0Entry && !extReset;
    endsequence

    AST_HALT_CLOCK: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == ST_HALT |-> oscRun && !cpuClockEn) else $error("suspend clock gating wrong");
    AST_STOP_OSC: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == ST_STOP |-> !oscRun && !cpuClockEn && !timerBRun && timerBClear && !intervalTimerRun)
        else $error("deep sleep left clocks or timers running");
    AST_STOP_PERIPH: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == ST_STOP && $past(state_reg) == ST_STOP |-> !adcRun && conversionResultClear
        && serialRun == $past(serialExtClock)) else $error("deep sleep peripheral state wrong");
    AST_ENTRY_BLOCK: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == ST_RUN && haltInstr && standbyOperand[OP_IRQ] && anyPend && !stopInstr
        |=> state_reg != ST_HALT) else $error("suspend entered with selected request pending");
    AST_HALT_VECTOR: assert property (@(posedge ref_clk) disable iff (srst)
        seqHaltWake |=> pcLoad && pcLoadAddr == $past(vecAddrNow) && !resumeNext ##1 !globalIrqEnable)
        else $error("wrong vector after suspend wake");
    AST_STOP_ZERO: assert property (@(posedge ref_clk) disable iff (srst)
        seqStop0Entry |=> initPulse && resetKind == RK_STOP0 && portsForceInput ##1 state_reg == ST_STOP
        || extReset) else $error("zero operand deep sleep not handled");
    AST_SETTLE_LEN: assert property (@(posedge ref_clk) disable iff (srst)
        settleDone && !extReset |-> settleCycles_reg == settleTarget) else $error("settling wait length wrong");
    AST_SOFT_RESET: assert property (@(posedge ref_clk) disable iff (srst)
        softReset && !extReset |=> initPulse && pcLoad && pcLoadAddr == ADDR_RESET && state_reg == ST_RUN)
        else $error("watchdog or stack reset did not restart at once");
    AST_RESET_VALUES: assert property (@(posedge ref_clk) disable iff (srst)
        initPulse |-> stackPointerInit == SP_RESET && timerModuloInit == TMR_MOD_RESET && !globalIrqEnable)
        else $error("reset presets wrong");
    AST_IRQ_ACCEPT: assert property (@(posedge ref_clk) disable iff (srst)
        irqAccept |=> !globalIrqEnable) else $error("global enable not cleared on accept");

endmodule

// file: test/sbr_core_model.sv
// Behavioural model of the interrupt flag logic facing the controller
`timescale 1ns/100ps
module sbr_core_model
    import sbr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [SRC_N-1:0] setReq,
    input wire logic [SRC_N-1:0] clrReq,
    input wire logic initPulse,
    input wire logic pcLoad,
    input wire logic [10:0] pcLoadAddr,
    output logic [SRC_N-1:0] sourceRequestFlag,
    output logic irqAccept
);
    // ======================================================
    // Request flags, preset after reset, a taken vector clears its own flag
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sourceRequestFlag <= '0;
        end else if (initPulse) begin
            sourceRequestFlag <= 5'h0c;
        end else begin
            sourceRequestFlag <= (sourceRequestFlag | setReq) & ~clrReq;
            if (pcLoad && pcLoadAddr != ADDR_RESET) begin
                sourceRequestFlag[3'(VEC_TOP - pcLoadAddr)] <= 1'b0;
            end
        end
    end

    // Core acknowledges a vectored resume one cycle late, as a slow core would
    always_ff @(posedge ref_clk) begin
        irqAccept <= !srst && pcLoad && pcLoadAddr != ADDR_RESET;
    end
endmodule

// file: test/tb_standby_and_reset_control.sv
// Self-checking bench for the standby and reset controller
`timescale 1ns/100ps
module tb_standby_and_reset_control;
    import sbr_pkg::*;
    localparam int PUL = 4;
    localparam int DIV = 2;
    logic ref_clk, srst, resetPinN, powerOnDetector, wakePinN, watchdogOverflow, stackFault;
    logic haltInstr, stopInstr, irqEnableInstr, irqDisableInstr, irqAccept, timerAPinSource, serialExtClock;
    logic [3:0] standbyOperand;
    logic [SRC_N-1:0] sourceRequestFlag, sourceEnableBit, setReq, clrReq, en, f;
    logic [7:0] timerBModulo, timerBDivisor, timerModuloInit, n, m;
    logic oscRun, cpuClockEn, coreReset, initPulse, keepDataMemory, portLatchClear, timerBCountClear;
    logic portsForceInput, pcLoad, resumeNext, globalIrqEnable, timerARun, timerBRun, timerBClear;
    logic intervalTimerRun, serialRun, adcRun, conversionResultClear, a, s;
    logic [1:0] resetKind;
    logic [10:0] pcLoadAddr;
    logic [2:0] stackPointerInit;
    int n_fail, n_compared, cnt;

    // ======================================================
    // Design, partner and clock
    sbr_standby_reset_ctrl #(.RESET_SETTLE_PULSES(PUL), .RESET_SETTLE_DIV(DIV)) DUT (
        .ref_clk, .srst, .resetPinN, .powerOnDetector, .wakePinN, .watchdogOverflow, .stackFault,
        .haltInstr, .stopInstr, .standbyOperand, .sourceRequestFlag, .sourceEnableBit,
        .irqEnableInstr, .irqDisableInstr, .irqAccept, .timerBModulo, .timerBDivisor,
        .timerAPinSource, .serialExtClock, .oscRun, .cpuClockEn, .coreReset, .initPulse, .resetKind,
        .keepDataMemory, .portLatchClear, .timerBCountClear, .portsForceInput, .pcLoad, .pcLoadAddr,
        .resumeNext, .globalIrqEnable, .timerARun, .timerBRun, .timerBClear, .intervalTimerRun,
        .serialRun, .adcRun, .conversionResultClear, .stackPointerInit, .timerModuloInit);
    sbr_core_model PARTNER (.ref_clk, .srst, .setReq, .clrReq, .initPulse, .pcLoad, .pcLoadAddr,
        .sourceRequestFlag, .irqAccept);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ======================================================
    // Checking and waiting helpers
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic sig(int w);
        case (w)
            0: return cpuClockEn;
            1: return oscRun;
            2: return pcLoad;
            3: return resumeNext;
            default: return initPulse;
        endcase
    endfunction

    // Bounded wait; a hang ends the run instead of stalling it
    task automatic wait_for(int w, logic lvl, int bound);
        cnt = 0;
        while (sig(w) !== lvl) begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt > bound) begin
                n_fail++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, sig(w), lvl);
                end_sim();
            end
        end
    endtask

    // Highest priority is the lowest source index
    function automatic logic [10:0] exp_vec(logic [SRC_N-1:0] v);
        for (int i = 0; i < SRC_N; i++) begin
            if (v[i]) begin
                return VEC_TOP - 11'(i);
            end
        end
        return ADDR_RESET;
    endfunction

    // Instruction pulse, then two edges so the answer has landed
    task automatic instr(logic stop, logic [3:0] op);
        @(posedge ref_clk);
        haltInstr <= !stop;
        stopInstr <= stop;
        standbyOperand <= op;
        @(posedge ref_clk);
        haltInstr <= 1'b0;
        stopInstr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic req(logic [SRC_N-1:0] sv, logic [SRC_N-1:0] cv);
        @(posedge ref_clk);
        setReq <= sv;
        clrReq <= cv;
        @(posedge ref_clk);
        setReq <= '0;
        clrReq <= '0;
        #1;
    endtask

    task automatic irq_en(logic ei);
        @(posedge ref_clk);
        irqEnableInstr <= ei;
        irqDisableInstr <= !ei;
        @(posedge ref_clk);
        irqEnableInstr <= 1'b0;
        irqDisableInstr <= 1'b0;
    endtask

    // ======================================================
    // Main sequence
    initial begin
        {srst, resetPinN, wakePinN, timerBDivisor} = {3'h7, 8'h01};
        {powerOnDetector, watchdogOverflow, stackFault, haltInstr, stopInstr} = '0;
        {irqEnableInstr, irqDisableInstr, timerAPinSource, serialExtClock, standbyOperand} = '0;
        {sourceEnableBit, setReq, clrReq, timerBModulo} = '0;
        n_fail = 0;
        n_compared = 0;
        void'($urandom(32'h3030));
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        wait_for(0, 1'b1, 200);
        chk_val(cnt >= PUL * DIV, 1);
        chk_val(stackPointerInit, 3'h5);
        chk_val(timerModuloInit, 8'hff);
        chk_val(globalIrqEnable, 0);
        // Reset left the interval flag pending: enabled, it blocks suspend
        sourceEnableBit <= 5'h08;
        instr(0, 4'h8);
        chk_val(cpuClockEn, 1);
        req('0, '1);
        // Suspend woken by random enabled requests, vectored or not
        for (int k = 0; k < 8; k++) begin
            en = 5'($urandom_range(1, 31));
            f = 5'($urandom) & en;
            f = (f == 0) ? en : f;
            irq_en(k[0]);
            sourceEnableBit <= en;
            instr(0, 4'h8);
            chk_val({cpuClockEn, oscRun, timerBRun}, 3'h3);
            req(f, '0);
            wait_for(k[0] ? 2 : 3, 1'b1, 10);
            if (k[0]) begin
                chk_val(pcLoadAddr, exp_vec(f));
                #5;
                chk_val(globalIrqEnable, 0);
            end
            req('0, '1);
        end
        // Forced timer B wake with its enable off
        sourceEnableBit <= '0;
        instr(0, 4'h2);
        chk_val(cpuClockEn, 0);
        req(5'h04, '0);
        wait_for(3, 1'b1, 10);
        req('0, '1);
        // Zero operand suspend ignores everything but reset
        instr(0, 4'h0);
        sourceEnableBit <= '1;
        req('1, '0);
        wakePinN <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        chk_val(cpuClockEn, 0);
        wakePinN <= 1'b1;
        powerOnDetector <= 1'b1;
        repeat (4) @(posedge ref_clk);
        powerOnDetector <= 1'b0;
        wait_for(4, 1'b1, 200);
        chk_val({keepDataMemory, portLatchClear, timerBCountClear}, 3'h7);
        wait_for(0, 1'b1, 5);
        req('0, '1);
        sourceEnableBit <= '0;
        // Deep sleep with random settling figures and peripheral sources
        for (int k = 0; k < 4; k++) begin
            n = 8'($urandom_range(0, 5));
            m = 8'($urandom_range(1, 4));
            {a, s} = 2'($urandom);
            {timerBModulo, timerBDivisor, timerAPinSource, serialExtClock} <= {n, m, a, s};
            instr(1, 4'h9);
            timerBModulo <= 8'hff;
            chk_val({oscRun, cpuClockEn, timerBClear, timerBRun}, 4'h2);
            chk_val({timerARun, intervalTimerRun, serialRun}, {a, 1'b0, s});
            chk_val({adcRun, conversionResultClear, portsForceInput}, 3'h2);
            wakePinN <= 1'b0;
            wait_for(1, 1'b1, 10);
            wait_for(0, 1'b1, 2000);
            chk_val(cnt >= (n + 1) * m && cnt <= (n + 1) * m + 2, 1);
            wakePinN <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        // Low release pin makes deep sleep a no-op
        wakePinN <= 1'b0;
        repeat (3) @(posedge ref_clk);
        instr(1, 4'h9);
        chk_val(oscRun, 1);
        wakePinN <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Soft resets skip the settling wait
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            watchdogOverflow <= !k[0];
            stackFault <= k[0];
            @(posedge ref_clk);
            {watchdogOverflow, stackFault} <= 2'h0;
            // The strobe launches on this edge; look once it has settled
            #1;
            wait_for(4, 1'b1, 4);
            chk_val({resetKind, pcLoad, pcLoadAddr}, {2'(k + 1), 1'b1, ADDR_RESET});
            chk_val({coreReset, portLatchClear, portsForceInput}, 3'h1);
            wait_for(0, 1'b1, 5);
        end
        // Zero operand deep sleep: ports to input, only the reset pin or power-on detector wakes
        irq_en(1);
        instr(1, 4'h0);
        chk_val({portsForceInput, oscRun, globalIrqEnable}, 3'h4);
        wakePinN <= 1'b0;
        req('1, '0);
        repeat (8) @(posedge ref_clk);
        #1;
        chk_val(oscRun, 0);
        {wakePinN, resetPinN} <= 2'h2;
        repeat (4) @(posedge ref_clk);
        resetPinN <= 1'b1;
        wait_for(0, 1'b1, 200);
        chk_val({keepDataMemory, coreReset}, 2'h2);
        end_sim();
    end
endmodule
